// File: bench/cdp_host_model.sv
// Purpose: Host bus controller model driving the codec port pins
// Assumes: Pins change at the falling clock edge
// Notes:   Released data lines show the inverse of the last value
module cdp_host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] data_i,
  input  wire logic       oe_n_i,
  output logic            cs_n_o,
  output logic            rd_n_o,
  output logic            wr_n_o,
  output logic      [1:0] addr_o,
  output logic      [7:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {cs_n_o, rd_n_o, wr_n_o} = 3'h7;
    addr_o = 2'h0;
    data_o = 8'h00;
  end

  // Strobe held well past the two-flop sync before release
  task automatic bus_wr(input logic [1:0] a, input logic [7:0] d);
    @(negedge clk_i);
    {cs_n_o, wr_n_o} = 2'h0;
    addr_o = a;
    data_o = d;
    repeat (4) @(negedge clk_i);
    {cs_n_o, wr_n_o} = 2'h3;
    repeat (4) @(negedge clk_i);
    data_o = ~d;
  endtask

  // A read during a flag change may see 0; callers poll again
  task automatic bus_rd(input logic [1:0] a, output logic [7:0] d);
    int n;
    @(negedge clk_i);
    {cs_n_o, rd_n_o} = 2'h0;
    addr_o = a;
    for (n = 0; n < 12 && oe_n_i !== 1'b0; n++) @(negedge clk_i);
    d = (oe_n_i === 1'b0) ? data_i : 8'hxx;
    @(negedge clk_i);
    {cs_n_o, rd_n_o} = 2'h3;
    repeat (4) @(negedge clk_i);
  endtask
endmodule

// File: bench/codec_host_direct_register_port_tb_top.sv
// Purpose: Self-checking bench for the codec host register port
// Assumes: Host bus model issues one access at a time
// Notes:   Converter events are single-cycle pulses from the bench
module codec_host_direct_register_port_tb_top
  import cdp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, srst, init_busy, gate, fmt16, stereo;
  logic [3:0]  ev;
  logic [31:0] cap_word, pb_word;
  wire         cs_n, rd_n, wr_n, oe_n, irq, tick, cap_ovr, pb_und, boost;
  wire         mode_en, xfer_dis;
  wire  [1:0]  adr, src;
  wire  [7:0]  hd_in, hd_out;
  wire  [3:0]  gain;
  int          err_count, check_count, n;
  logic [7:0]  rv;
  logic [7:0]  cap_exp [5] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h44};
  logic [7:0]  cap_st  [5] = '{8'he0, 8'h20, 8'ha0, 8'h80, 8'h80};

  cdp_host_port u_cdp_host_port (
    .clk_i(clk), .srst_i(srst), .cs_n_i(cs_n), .rd_n_i(rd_n),
    .wr_n_i(wr_n), .direct_select_lines_i(adr), .host_data_i(hd_in),
    .host_data_o(hd_out), .host_data_oe_n_o(oe_n),
    .init_busy_i(init_busy), .irq_pin_gate_i(gate),
    .dma_count_underflow_i(ev[0]), .timer_underflow_i(ev[1]),
    .fmt16_i(fmt16), .stereo_i(stereo), .adc_sample_valid_i(ev[2]),
    .capture_word_i(cap_word), .dac_sample_take_i(ev[3]),
    .playback_word_o(pb_word), .irq_o(irq), .timer_tick_o(tick),
    .capture_overrun_flag_o(cap_ovr), .playback_underrun_flag_o(pb_und),
    .left_gain_field_o(gain), .left_mic_boost_o(boost),
    .left_source_field_o(src), .mode_change_en_o(mode_en),
    .xfer_req_dis_o(xfer_dis)
  );

  cdp_host_model u_cdp_host_model (
    .clk_i(clk), .data_i(hd_out), .oe_n_i(oe_n), .cs_n_o(cs_n),
    .rd_n_o(rd_n), .wr_n_o(wr_n), .addr_o(adr), .data_o(hd_in)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(logic [1:0] a, logic [7:0] d);
    u_cdp_host_model.bus_wr(a, d);
  endtask

  task automatic rdc(string nm, logic [1:0] a, logic [7:0] m,
                     logic [7:0] e);
    u_cdp_host_model.bus_rd(a, rv);
    chk(nm, {24'h0, e}, {24'h0, rv & m});
  endtask

  task automatic wait_st(int b);
    for (int i = 0; i < 60; i++) begin
      u_cdp_host_model.bus_rd(ADR_STATUS, rv);
      if (rv[b] === 1'b1) break;
    end
    if (rv[b] !== 1'b1) begin
      err_count++;
      $display("[FAIL] status bit %0d expected 1 seen %b", b, rv[b]);
    end
  endtask

  // Pulse then let registered flags settle
  task automatic pulse(int b);
    @(negedge clk);
    ev[b] = 1'b1;
    @(negedge clk);
    ev[b] = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  initial begin
    #100us;
    err_count++;
    $display("[FAIL] watchdog expected done seen hang");
    wrap_up();
  end

  initial begin
    {srst, init_busy, gate, fmt16, stereo} = 5'h10;
    ev = 4'h0;
    cap_word = 32'h44332211;
    err_count = 0;
    check_count = 0;
    repeat (4) @(negedge clk);
    srst = 1'b0;
    rdc("status_rst", ADR_STATUS, 8'hff, STATUS_RST);
    rdc("index_rst", ADR_INDEX, 8'hff, 8'h40);
    chk("mode_bits", 32'h2, {30'h0, mode_en, xfer_dis});
    wait_st(1);
    rdc("pb_8mono", ADR_STATUS, 8'h0e, 8'h0e);
    wr(ADR_PIO, 8'h5a);
    wr(ADR_PIO, 8'h77);
    rdc("pb_full", ADR_STATUS, 8'h02, 8'h00);
    pulse(3);
    chk("pb_byte", 32'h5a, {24'h0, pb_word[7:0]});
    chk("pb_under0", 32'h0, {31'h0, pb_und});
    {fmt16, stereo} = 2'h3;
    pulse(3);
    chk("pb_under1", 32'h1, {31'h0, pb_und});
    wait_st(1);
    rdc("pb_16st", ADR_STATUS, 8'h1e, 8'h16);
    for (int i = 1; i < 5; i++) wr(ADR_PIO, 8'(i));
    pulse(3);
    chk("pb_word", 32'h04030201, pb_word);
    pulse(2);
    wait_st(5);
    rdc("cap_first", ADR_STATUS, 8'he0, 8'h60);
    for (int i = 0; i < 5; i++) begin
      rdc("cap_data", ADR_PIO, 8'hff, cap_exp[i]);
      rdc("cap_flags", ADR_STATUS, 8'he0, cap_st[i]);
    end
    pulse(2);
    wait_st(5);
    rdc("cap_restart", ADR_STATUS, 8'he0, 8'h60);
    pulse(2);
    chk("cap_overrun", 32'h1, {31'h0, cap_ovr});
    rdc("sample_overunder_flag", ADR_STATUS, 8'h10, 8'h10);
    rdc("int_idle", ADR_STATUS, 8'h01, 8'h00);
    pulse(1);
    chk("irq_gated", 32'h0, {31'h0, irq});
    rdc("int_set", ADR_STATUS, 8'h01, 8'h01);
    gate = 1'b1;
    repeat (2) @(negedge clk);
    chk("irq_on", 32'h1, {31'h0, irq});
    wr(ADR_STATUS, 8'h5c);
    rdc("int_clr", ADR_STATUS, 8'h01, 8'h00);
    chk("irq_off", 32'h0, {31'h0, irq});
    pulse(0);
    chk("irq_dma", 32'h1, {31'h0, irq});
    wr(ADR_STATUS, 8'h00);
    gate = 1'b0;
    wr(ADR_INDEX, 8'h00);
    wr(ADR_DATA, 8'hff);
    rdc("left_in", ADR_DATA, 8'hff, LEFT_IN_WMASK);
    chk("left_fld", 32'hef, {24'h0, src, boost, 1'b0, gain});
    for (int s = 0; s < 3; s++) begin
      wr(ADR_DATA, {2'(s), 6'h05});
      chk("left_src", 32'(s), {30'h0, src});
    end
    wr(ADR_INDEX, 8'h11);
    rdc("index_mask", ADR_INDEX, 8'hff, 8'h01);
    chk("mode_clr", 32'h0, {30'h0, mode_en, xfer_dis});
    rdc("other_ix", ADR_DATA, 8'hff, 8'h00);
    wr(ADR_INDEX, 8'h10);
    rdc("top_bit", ADR_DATA, 8'hff, 8'h85);
    init_busy = 1'b1;
    wr(ADR_DATA, 8'h3c);
    wr(ADR_PIO, 8'h99);
    rdc("init_data", ADR_DATA, 8'hff, INIT_READ);
    rdc("init_pio", ADR_PIO, 8'hff, INIT_READ);
    init_busy = 1'b0;
    rdc("init_kept", ADR_DATA, 8'hff, 8'h85);
    pulse(3);
    chk("init_pb", 32'h1, {31'h0, pb_und});
    n = 0;
    while (tick !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    n = 1;
    while (tick !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chk("tick_gap", 32'(TICK_CYC), 32'(n));
    wrap_up();
  end
endmodule

// File: logic/cdp_byte_track.sv
// Purpose: Byte position tracker for one PIO sample direction
// Assumes: Bytes go left before right, lower before upper
// Notes:   Format is latched at each sample boundary
module cdp_byte_track
  import cdp_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic       fmt16_i,
  input  wire logic       stereo_i,
  input  wire logic       restart_i,
  input  wire logic       step_i,
  output logic      [2:0] cnt_o,
  output logic            last_o,
  output logic            full_o,
  output logic            chan_flag_o,
  output logic            byte_flag_o
);
  logic       fmt16_reg;
  logic       stereo_reg;
  logic [2:0] cnt_reg;
  logic [2:0] nbytes;
  logic [2:0] half;

  assign nbytes      = 3'h1 << ({2'h0, stereo_reg} + {2'h0, fmt16_reg});
  assign half        = nbytes >> 1;
  assign cnt_o       = cnt_reg;
  assign last_o      = (cnt_reg == nbytes - 3'h1);
  assign full_o      = (cnt_reg == nbytes);
  assign chan_flag_o = ~stereo_reg | (cnt_reg < half);
  assign byte_flag_o = ~fmt16_reg | cnt_reg[0];

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      fmt16_reg  <= FMT16_RST;
      stereo_reg <= STEREO_RST;
      cnt_reg    <= 3'h0;
    end else if (restart_i) begin
      fmt16_reg  <= fmt16_i;
      stereo_reg <= stereo_i;
      cnt_reg    <= 3'h0;
    end else if (step_i && !full_o) begin
      cnt_reg <= cnt_reg + 3'h1;
    end
  end
endmodule

// File: logic/cdp_host_port.sv
// Purpose: Direct register port of the codec facing the host bus
// Assumes: Host strobes are asynchronous; codec events are on clk_i
// Notes:   Bus data out is valid while host_data_oe_n_o is low
module cdp_host_port
  import cdp_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        cs_n_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  input  wire logic [1:0]  direct_select_lines_i,
  input  wire logic [7:0]  host_data_i,
  output logic      [7:0]  host_data_o,
  output logic             host_data_oe_n_o,
  input  wire logic        init_busy_i,
  input  wire logic        irq_pin_gate_i,
  input  wire logic        dma_count_underflow_i,
  input  wire logic        timer_underflow_i,
  input  wire logic        fmt16_i,
  input  wire logic        stereo_i,
  input  wire logic        adc_sample_valid_i,
  input  wire logic [31:0] capture_word_i,
  input  wire logic        dac_sample_take_i,
  output logic      [31:0] playback_word_o,
  output logic             irq_o,
  output logic             timer_tick_o,
  output logic             capture_overrun_flag_o,
  output logic             playback_underrun_flag_o,
  output logic      [3:0]  left_gain_field_o,
  output logic             left_mic_boost_o,
  output logic      [1:0]  left_source_field_o,
  output logic             mode_change_en_o,
  output logic             xfer_req_dis_o
);
  // Pin synchroniser: {cs_n, rd_n, wr_n, addr, data}
  logic [12:0] pin_meta_reg;
  logic [12:0] pin_sync_reg;
  logic        rd_prev_reg;
  logic        wr_prev_reg;
  logic [1:0]  rd_addr_reg;
  logic [1:0]  wr_addr_reg;
  logic [7:0]  wr_data_reg;
  logic [7:0]  rd_data_reg;
  logic        oe_n_reg;
  logic [6:0]  index_reg;
  logic [7:0]  left_ctrl_reg;
  logic        int_reg;
  logic        irq_reg;
  logic        sample_overunder_flag_reg;
  logic        ovr_flag_reg;
  logic        und_flag_reg;
  logic        cap_rdy_reg;
  logic        cap_rdy_pend_reg;
  logic        play_rdy_reg;
  logic        play_rdy_pend_reg;
  logic [6:0]  gap_cnt_reg;
  logic [31:0] cap_word_reg;
  logic [31:0] play_buf_reg;
  logic [31:0] play_word_reg;
  logic [11:0] tick_cnt_reg;
  logic        tick_reg;

  logic        s_cs_n;
  logic        s_rd_n;
  logic        s_wr_n;
  logic [1:0]  s_addr;
  logic        rd_act;
  logic        wr_act;
  logic        rd_start;
  logic        rd_end;
  logic        wr_end;
  logic        wr_ok;
  logic        gap_ok;
  logic        cap_rise;
  logic        play_rise;
  logic        cap_step;
  logic        play_step;
  logic        cap_last;
  logic        cap_done;
  logic        cap_chan;
  logic        cap_byte;
  logic        play_full;
  logic        play_chan;
  logic        play_byte;
  logic        overrun;
  logic        underrun;
  logic        int_next;
  logic [2:0]  cap_cnt;
  logic [2:0]  play_cnt;
  logic [7:0]  status_now;
  logic [7:0]  indexed_rd;
  logic [7:0]  cap_byte_rd;
  logic [7:0]  direct_rd;
  logic [7:0]  rd_next;

  assign s_cs_n   = pin_sync_reg[12];
  assign s_rd_n   = pin_sync_reg[11];
  assign s_wr_n   = pin_sync_reg[10];
  assign s_addr   = pin_sync_reg[9:8];
  assign rd_act   = ~s_cs_n & ~s_rd_n;
  assign wr_act   = ~s_cs_n & ~s_wr_n;
  assign rd_start = rd_act & ~rd_prev_reg;
  assign rd_end   = ~rd_act & rd_prev_reg;
  assign wr_end   = ~wr_act & wr_prev_reg;
  assign wr_ok    = wr_end & ~init_busy_i;

  // Byte trackers for both directions
  cdp_byte_track u_cap_track (
    .clk_i       (clk_i),
    .srst_i      (srst_i),
    .fmt16_i     (fmt16_i),
    .stereo_i    (stereo_i),
    .restart_i   (adc_sample_valid_i),
    .step_i      (cap_step),
    .cnt_o       (cap_cnt),
    .last_o      (cap_last),
    .full_o      (),
    .chan_flag_o (cap_chan),
    .byte_flag_o (cap_byte)
  );

  cdp_byte_track u_play_track (
    .clk_i       (clk_i),
    .srst_i      (srst_i),
    .fmt16_i     (fmt16_i),
    .stereo_i    (stereo_i),
    .restart_i   (dac_sample_take_i),
    .step_i      (play_step),
    .cnt_o       (play_cnt),
    .last_o      (),
    .full_o      (play_full),
    .chan_flag_o (play_chan),
    .byte_flag_o (play_byte)
  );

  // Capture read steps until the last byte, then holds
  assign cap_done  = rd_end & (rd_addr_reg == ADR_PIO) & ~init_busy_i;
  assign cap_step  = cap_done & ~cap_last;
  // Playback write steps until full
  assign play_step = wr_ok & (wr_addr_reg == ADR_PIO);

  // Ready spacing between consecutive samples
  assign gap_ok    = (gap_cnt_reg == RDY_GAP_MAX);
  assign cap_rise  = cap_rdy_pend_reg & gap_ok & ~adc_sample_valid_i;
  assign play_rise = play_rdy_pend_reg & gap_ok & ~play_full & ~cap_rise
                     & ~dac_sample_take_i;
  assign overrun   = adc_sample_valid_i & (cap_rdy_reg | cap_rdy_pend_reg);
  assign underrun  = dac_sample_take_i & ~play_full;

  // Set wins over a host clear
  assign int_next = (dma_count_underflow_i | timer_underflow_i) ? 1'b1 :
                    (wr_end & (wr_addr_reg == ADR_STATUS)) ? 1'b0 : int_reg;

  assign status_now = {cap_byte, cap_chan, cap_rdy_reg, sample_overunder_flag_reg,
                       play_byte, play_chan, play_rdy_reg, int_reg};
  // Only index bits 3:0 decode; the top bit is inactive
  assign indexed_rd  = (index_reg[3:0] == IDX_LEFT_IN) ? left_ctrl_reg
                                                        : 8'h00;
  assign cap_byte_rd = cap_word_reg[{cap_cnt[1:0], 3'b000} +: 8];
  assign direct_rd   = (s_addr == ADR_INDEX) ? {1'b0, index_reg} :
                       (s_addr == ADR_DATA)  ? indexed_rd : cap_byte_rd;
  // Initializing reads give 80h except status
  assign rd_next = (s_addr == ADR_STATUS) ? status_now :
                   init_busy_i ? INIT_READ : direct_rd;

  assign host_data_o              = rd_data_reg;
  assign host_data_oe_n_o         = oe_n_reg;
  assign playback_word_o          = play_word_reg;
  assign irq_o                    = irq_reg;
  assign timer_tick_o             = tick_reg;
  assign capture_overrun_flag_o   = ovr_flag_reg;
  assign playback_underrun_flag_o = und_flag_reg;
  assign left_gain_field_o        = left_ctrl_reg[LG_LSB +: 4];
  assign left_mic_boost_o         = left_ctrl_reg[LMB_BIT];
  assign left_source_field_o      = left_ctrl_reg[LSRC_LSB +: 2];
  assign mode_change_en_o         = index_reg[IX_MCE];
  assign xfer_req_dis_o           = index_reg[IX_TRD];

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pin_meta_reg <= 13'h1c00;
      pin_sync_reg <= 13'h1c00;
      rd_prev_reg  <= 1'b0;
      wr_prev_reg  <= 1'b0;
      oe_n_reg     <= 1'b1;
    end else begin
      pin_meta_reg <= {cs_n_i, rd_n_i, wr_n_i, direct_select_lines_i,
                       host_data_i};
      pin_sync_reg <= pin_meta_reg;
      rd_prev_reg  <= rd_act;
      wr_prev_reg  <= wr_act;
      oe_n_reg     <= ~rd_act;
    end
  end

  // One snapshot per read strobe
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rd_data_reg <= 8'h00;
      rd_addr_reg <= ADR_INDEX;
      wr_addr_reg <= ADR_INDEX;
      wr_data_reg <= 8'h00;
    end else begin
      if (rd_start) begin
        rd_data_reg <= rd_next;
        rd_addr_reg <= s_addr;
      end
      if (wr_act) begin
        wr_addr_reg <= s_addr;
        wr_data_reg <= pin_sync_reg[7:0];
      end
    end
  end

  // Index and indirect register writes
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      index_reg     <= INDEX_RST;
      left_ctrl_reg <= LEFT_IN_RST;
    end else if (wr_ok && wr_addr_reg == ADR_INDEX) begin
      index_reg <= wr_data_reg[6:0] & INDEX_WMASK;
    end else if (wr_ok && wr_addr_reg == ADR_DATA &&
                 index_reg[3:0] == IDX_LEFT_IN) begin
      left_ctrl_reg <= wr_data_reg & LEFT_IN_WMASK;
    end
  end

  // Interrupt flag and gated pin
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      int_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      int_reg <= int_next;
      irq_reg <= int_reg & irq_pin_gate_i;
    end
  end

  // 10 us timer tick
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tick_cnt_reg <= 12'h000;
      tick_reg     <= 1'b0;
    end else begin
      tick_reg     <= (tick_cnt_reg == TICK_MAX);
      tick_cnt_reg <= (tick_cnt_reg == TICK_MAX) ? 12'h000
                                                 : tick_cnt_reg + 12'h001;
    end
  end

  // Per-sample error flags
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sample_overunder_flag_reg     <= 1'b0;
      ovr_flag_reg <= 1'b0;
      und_flag_reg <= 1'b0;
    end else if (adc_sample_valid_i || dac_sample_take_i) begin
      sample_overunder_flag_reg <= overrun | underrun;
      if (adc_sample_valid_i) begin
        ovr_flag_reg <= overrun;
      end
      if (dac_sample_take_i) begin
        und_flag_reg <= underrun;
      end
    end
  end

  // Ready bits
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cap_rdy_reg       <= 1'b0;
      cap_rdy_pend_reg  <= 1'b0;
      play_rdy_reg      <= 1'b0;
      play_rdy_pend_reg <= 1'b1;
      gap_cnt_reg       <= 7'h00;
    end else begin
      if (adc_sample_valid_i || (cap_done && cap_last)) begin
        cap_rdy_reg <= 1'b0;
      end else if (cap_rise) begin
        cap_rdy_reg <= 1'b1;
      end
      if (adc_sample_valid_i) begin
        cap_rdy_pend_reg <= 1'b1;
      end else if (cap_rise) begin
        cap_rdy_pend_reg <= 1'b0;
      end
      if (dac_sample_take_i || play_full) begin
        play_rdy_reg <= 1'b0;
      end else if (play_rise) begin
        play_rdy_reg <= 1'b1;
      end
      if (dac_sample_take_i) begin
        play_rdy_pend_reg <= 1'b1;
      end else if (play_rise) begin
        play_rdy_pend_reg <= 1'b0;
      end
      if (cap_rise || play_rise) begin
        gap_cnt_reg <= 7'h00;
      end else if (!gap_ok) begin
        gap_cnt_reg <= gap_cnt_reg + 7'h01;
      end
    end
  end

  // Sample data
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cap_word_reg  <= 32'h0000_0000;
      play_buf_reg  <= 32'h0000_0000;
      play_word_reg <= 32'h0000_0000;
    end else begin
      if (adc_sample_valid_i) begin
        cap_word_reg <= capture_word_i;
      end
      if (dac_sample_take_i) begin
        play_word_reg <= play_buf_reg;
      end else if (play_step && !play_full) begin
        play_buf_reg[{play_cnt[1:0], 3'b000} +: 8] <= wr_data_reg;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  a_int_clear:
    assert property (wr_end && wr_addr_reg == ADR_STATUS &&
      !dma_count_underflow_i && !timer_underflow_i |=> !int_reg)
    else $error("interrupt flag not cleared by status write");
  a_int_cause:
    assert property ($rose(int_reg) |->
      $past(dma_count_underflow_i || timer_underflow_i))
    else $error("interrupt flag set without underflow");
  a_irq_pin_gate:
    assert property (int_reg && irq_pin_gate_i |=> irq_reg)
    else $error("interrupt pin not driven while gated on");
  a_init_read:
    assert property (rd_start && init_busy_i && s_addr != ADR_STATUS
      |=> host_data_o == INIT_READ)
    else $error("read during init not 80h");
  a_status_reset:
    assert property ($fell(srst_i) |-> status_now == STATUS_RST)
    else $error("status not 1100 1100 after reset");
  a_ready_gap:
    assert property ($rose(play_rdy_reg) || $rose(cap_rdy_reg) |->
      $past(gap_cnt_reg) == RDY_GAP_MAX)
    else $error("ready indications too close");
  a_play_ignore:
    assert property (play_step && play_full && !dac_sample_take_i
      |=> $stable(play_buf_reg))
    else $error("playback write taken after sample full");
  a_cap_hold:
    assert property (cap_done && cap_last && !adc_sample_valid_i
      |=> $stable(cap_cnt) ##1 $stable(cap_cnt))
    else $error("capture tracker moved past last byte");
  a_sample_overunder_flag_track:
    assert property (underrun && !adc_sample_valid_i
      |=> sample_overunder_flag_reg && und_flag_reg)
    else $error("underrun not flagged");
  a_index_route:
    assert property (rd_start && !init_busy_i && s_addr == ADR_DATA &&
      index_reg[3:0] == IDX_LEFT_IN |=> host_data_o == $past(left_ctrl_reg))
    else $error("indexed read not routed to selected register");
  a_pio_write:
    assert property (play_step && !play_full && play_cnt == 3'h0 &&
      !dac_sample_take_i |=> play_buf_reg[7:0] == $past(wr_data_reg))
    else $error("playback byte not stored");
endmodule

// File: logic/cdp_pkg.sv
// Purpose: Constants for the codec host direct register port
// Assumes: 250 MHz core clock, byte-wide asynchronous host bus
// Notes:   Direct addresses are the two host select lines
// Summary of operation
// - Direct address 1 reaches the indirect register chosen by the index.
// - While initializing, address 1 ignores writes and reads 80h.
// - Interrupt flag is the only sticky bit; any status write clears it.
// - Interrupt pin shows the flag only when the pin gate is on.
// - Only DMA count or timer underflow may set the interrupt flag.
// - Interrupt timer ticks every 10 microseconds.
// - Playback ready is 1 when playback data is stale, 0 while valid.
// - Playback channel bit is 0 for right, 1 for left or mono.
// - Playback byte bit is 0 for lower, 1 for upper or 8-bit.
// - Over/underrun bit follows each sample; separate overrun/underrun flags.
// - Capture ready is 1 when capture data is fresh, 0 when stale.
// - Capture channel/byte bits: 0 right/lower, 1 left, mono, upper, 8-bit.
// - Ready and interrupt bits change freely; host rereads for new ones.
// - Consecutive ready indications are spaced about 320 to 600 ns.
// - Status reads 1100 1100 after reset.
// - Address 3 writes playback data and reads capture data.
// - While initializing, playback writes drop and capture reads give 80h.
// - Capture reads step through bytes, hold at last until new sample.
// - Playback writes step bytes; extra writes ignored until sample leaves.
// - Indirect register 0 holds 4-bit left gain and microphone boost.
// - Left source select 00 line, 01 aux 1, 10 microphone; reserved bit 4 reads 0.
// - Index field selects the indirect register; top bit inactive here.
package cdp_pkg;
  localparam int          CLK_MHZ       = 250;
  localparam logic [1:0]  ADR_INDEX     = 2'h0;
  localparam logic [1:0]  ADR_DATA      = 2'h1;
  localparam logic [1:0]  ADR_STATUS    = 2'h2;
  localparam logic [1:0]  ADR_PIO       = 2'h3;
  localparam logic [3:0]  IDX_LEFT_IN   = 4'h0;
  localparam logic [7:0]  INIT_READ     = 8'h80;
  localparam logic [7:0]  STATUS_RST    = 8'hcc;
  localparam logic [6:0]  INDEX_RST     = 7'h40;
  localparam logic [6:0]  INDEX_WMASK   = 7'h6f;
  localparam logic [7:0]  LEFT_IN_RST   = 8'h00;
  localparam logic [7:0]  LEFT_IN_WMASK = 8'hef;
  localparam int          IX_TRD        = 5;
  localparam int          IX_MCE        = 6;
  localparam int          LG_LSB        = 0;
  localparam int          LMB_BIT       = 5;
  localparam int          LSRC_LSB      = 6;
  localparam logic        FMT16_RST     = 1'b0;
  localparam logic        STEREO_RST    = 1'b0;
  localparam int          TICK_US       = 10;
  localparam int          TICK_CYC      = TICK_US * CLK_MHZ;
  localparam logic [11:0] TICK_MAX      = 12'(TICK_CYC - 1);
  localparam int          RDY_GAP_NS    = 320;
  localparam int          RDY_GAP_CYC   = (RDY_GAP_NS * CLK_MHZ + 999) / 1000;
  localparam logic [6:0]  RDY_GAP_MAX   = 7'(RDY_GAP_CYC - 1);
endpackage
